// File: azt_defs.svh
// Constants of the arc zone trip, blocking and operation logger block.
// What this block does
// - Trip only while blocking is inactive
// - Sample blocking once per program cycle start
// - Unblocked zone pick-up asserts zone trip
// - Blocked pick-up flags blocked, no trip
// - Blocking raises notice and logs event
// - Test mode lets software drive blocking
// - Status changes generate events, zone changes records
// - Per-message ON, OFF or both selection
// - Events carry time stamp and data
// - Condition code: even trip, odd blocked
// - Sensor status code 0 to 17
// - Separate ON and OFF events per source
// - Keep twelve most recent operation records
// - Record holds time, event, currents, sensors
// - Four zones with own channel selection
// - Digital input light or current mode
`ifndef AZT_DEFS_SVH
`define AZT_DEFS_SVH
`define AZT_CLK_NS 5
`define AZT_CYCLE_US 1000
`define AZT_CYCLE_CLKS (`AZT_CYCLE_US * 1000 / `AZT_CLK_NS)
`define AZT_BLOCK_LEAD_MS 5
`define AZT_NUM_REC 12
`define AZT_NUM_SRC 26
`define AZT_A_CTRL 8'h00
`define AZT_A_ZONE_EN 8'h04
`define AZT_A_ZONE_CFG0 8'h08
`define AZT_A_ON_SEL 8'h18
`define AZT_A_OFF_SEL 8'h1c
`define AZT_A_STATUS 8'h20
`define AZT_A_IRQ_STAT 8'h24
`define AZT_A_IRQ_EN 8'h28
`define AZT_A_IRQ_CLR 8'h2c
`define AZT_A_REC_SEL 8'h30
`define AZT_A_REC_TLO 8'h34
`define AZT_A_REC_THI 8'h38
`define AZT_A_REC_INFO 8'h3c
`define AZT_A_REC_AB 8'h40
`define AZT_A_REC_CR 8'h44
`define AZT_CFG_PH 0
`define AZT_CFG_RES 1
`define AZT_CFG_LIGHT 2
`define AZT_CFG_PRES 6
`define AZT_CFG_DI 10
`define AZT_DI_LIGHT 2'h1
`define AZT_DI_CURR 2'h2
`define AZT_SRC_SENSOR 8
`define AZT_IRQ_TRIP 0
`define AZT_IRQ_BLOCK 1
`define AZT_IRQ_REC 2
`endif

// File: azt_pkg.sv
// Types and shared helpers of the arc zone trip block.
package azt_pkg;
	typedef logic [4:0] azt_idx_type;
	typedef logic [11:0] azt_zcfg_type;
	// Index of the lowest set bit of a 32-bit vector, zero when none.
	function automatic azt_idx_type azt_first(input logic [31:0] v);
		azt_idx_type r;
		r = 5'h00;
		for (int i = 31; i >= 0; i--) begin
			if (v[i]) begin
				r = 5'(i);
			end
		end
		return r;
	endfunction
endpackage

// File: azt_arc_zone_trip.sv
// Arc zone trip and blocking decision, event generator and operation log.
//
// Local design decisions: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`include "azt_defs.svh"
module azt_arc_zone_trip import azt_pkg::*; #(
	parameter int CYCLE_CLKS = `AZT_CYCLE_CLKS
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic blockIn,
	input wire logic phaseBlocked,
	input wire logic phaseStart,
	input wire logic resBlocked,
	input wire logic resStart,
	input wire logic [3:0] chanLight,
	input wire logic [3:0] chanPressure,
	input wire logic optionDigitalInput,
	input wire logic [3:0] sensorFault,
	input wire logic ioUnitFault,
	input wire logic [63:0] timeNow,
	input wire logic [15:0] currentA,
	input wire logic [15:0] currentB,
	input wire logic [15:0] currentC,
	input wire logic [15:0] currentRes,
	input wire logic [2:0] settingGroup,
	output logic [3:0] zoneTrip,
	output logic [3:0] zoneBlocked,
	output logic displayNotify,
	output logic evtValid,
	output logic [5:0] evtCode,
	output logic [63:0] evtTime,
	output logic [63:0] evtCurrents,
	output logic irq
);
	// Program cycle divider, one-cycle tick at each cycle start.
	logic [31:0] divCnt_reg;
	wire tick = (divCnt_reg == 32'(CYCLE_CLKS - 1));
	always_ff @(posedge clk) begin
		if (!rstn || tick) begin
			divCnt_reg <= 32'h0;
		end else begin
			divCnt_reg <= divCnt_reg + 32'h1;
		end
	end

	// Software registers.
	logic [1:0] ctrl_reg; // Bit 0 forcing enable, bit 1 forced block.
	logic [3:0] zoneEn_reg; // One enable per zone.
	azt_zcfg_type zoneCfg_reg [4]; // Channel selection per zone.
	logic [25:0] onSel_reg; // Store ON edge of each source.
	logic [25:0] offSel_reg; // Store OFF edge of each source.
	logic [2:0] irqStat_reg; // Sticky interrupt causes.
	logic [2:0] irqEn_reg; // Interrupt enables.
	logic [3:0] recSel_reg; // Record to read, 0 is newest.

	// Test mode replaces the blocking matrix input with a switch.
	wire blockSrc = ctrl_reg[0] ? ctrl_reg[1] : blockIn;

	// The blocking level is caught once per cycle; the source must be
	// stable before the operating delay ends, which is its own duty.
	logic blockSampled_reg;
	always_ff @(posedge clk) begin
		if (!rstn) begin
			blockSampled_reg <= 1'b0;
		end else if (tick) begin
			blockSampled_reg <= blockSrc;
		end
	end

	// Zone pick-up from the selected channels of each zone.
	logic [3:0] pickup;
	always_comb begin
		for (int z = 0; z < 4; z++) begin
			logic [1:0] di;
			logic lit;
			logic prs;
			di = zoneCfg_reg[z][`AZT_CFG_DI +: 2];
			lit = |(zoneCfg_reg[z][`AZT_CFG_LIGHT +: 4] & chanLight);
			prs = |(zoneCfg_reg[z][`AZT_CFG_PRES +: 4] & chanPressure);
			pickup[z] = zoneEn_reg[z] & (
				(zoneCfg_reg[z][`AZT_CFG_PH] & phaseStart) |
				(zoneCfg_reg[z][`AZT_CFG_RES] & resStart) | lit | prs |
				((di == `AZT_DI_LIGHT) & optionDigitalInput) |
				((di == `AZT_DI_CURR) & optionDigitalInput &
				(|chanLight | |chanPressure)));
		end
	end

	// Decision at the cycle start uses the live blocking source, not the sampled copy.
	wire [3:0] tripNext = pickup & {4{~blockSrc}};
	wire [3:0] blockNext = pickup & {4{blockSrc}};
	always_ff @(posedge clk) begin
		if (!rstn) begin
			zoneTrip <= 4'h0;
			zoneBlocked <= 4'h0;
		end else if (tick) begin
			zoneTrip <= tripNext;
			zoneBlocked <= blockNext;
		end
	end

	// Event sources: trips at even and blocks at odd positions, then
	// the eighteen sensor sources in sensor status code order.
	wire [25:0] src = {ioUnitFault, sensorFault, optionDigitalInput,
		chanPressure[3], chanLight[3], chanPressure[2], chanLight[2],
		chanPressure[1], chanLight[1], chanPressure[0], chanLight[0],
		resStart, resBlocked, phaseStart, phaseBlocked,
		zoneBlocked[3], zoneTrip[3], zoneBlocked[2], zoneTrip[2],
		zoneBlocked[1], zoneTrip[1], zoneBlocked[0], zoneTrip[0]};
	logic [25:0] srcPrev_reg;
	logic sampleNow_reg; // Edge search runs one cycle after the tick.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			sampleNow_reg <= 1'b0;
		end else begin
			sampleNow_reg <= tick;
		end
	end
	wire [25:0] rise = sampleNow_reg ? (src & ~srcPrev_reg) : 26'h0;
	wire [25:0] fall = sampleNow_reg ? (~src & srcPrev_reg) : 26'h0;

	// Pending edges; a new edge wins over the emission that clears it.
	logic [25:0] pendOn_reg;
	logic [25:0] pendOff_reg;
	wire anyOn = |pendOn_reg;
	wire anyPend = anyOn | (|pendOff_reg);
	wire azt_idx_type selIdx = anyOn ? azt_first({6'h0, pendOn_reg}) :
		azt_first({6'h0, pendOff_reg});
	wire [25:0] selBit = 26'h1 << selIdx;
	wire [25:0] clrOn = (anyPend && anyOn) ? selBit : 26'h0;
	wire [25:0] clrOff = (anyPend && !anyOn) ? selBit : 26'h0;
	wire [25:0] pendOn_next = (pendOn_reg & ~clrOn) |
		(rise & onSel_reg);
	wire [25:0] pendOff_next = (pendOff_reg & ~clrOff) |
		(fall & offSel_reg);
	always_ff @(posedge clk) begin
		if (!rstn) begin
			srcPrev_reg <= 26'h0;
			pendOn_reg <= 26'h0;
			pendOff_reg <= 26'h0;
		end else begin
			if (sampleNow_reg) begin
				srcPrev_reg <= src;
			end
			pendOn_reg <= pendOn_next;
			pendOff_reg <= pendOff_next;
		end
	end

	// Process data caught with the edges, sent with every event.
	logic [63:0] snapTime_reg;
	logic [63:0] snapCur_reg;
	logic [7:0] snapSens_reg;
	always_ff @(posedge clk) begin
		if (!rstn) begin
			snapTime_reg <= 64'h0;
			snapCur_reg <= 64'h0;
			snapSens_reg <= 8'h0;
		end else if (sampleNow_reg) begin
			snapTime_reg <= timeNow;
			snapCur_reg <= {currentRes, currentC, currentB, currentA};
			snapSens_reg <= {chanPressure, chanLight};
		end
	end

	// One event leaves per clock, ON edges before OFF edges.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			evtValid <= 1'b0;
			evtCode <= 6'h00;
			evtTime <= 64'h0;
			evtCurrents <= 64'h0;
		end else begin
			evtValid <= anyPend;
			if (anyPend) begin
				evtCode <= {selIdx, ~anyOn};
				evtTime <= snapTime_reg;
				evtCurrents <= snapCur_reg;
			end
		end
	end

	// Front panel notice pulses when a new block appears.
	wire newBlock = |(rise[7:0] & 8'haa);
	always_ff @(posedge clk) begin
		if (!rstn) begin
			displayNotify <= 1'b0;
		end else begin
			displayNotify <= newBlock;
		end
	end

	// Operation log: the lowest zone trip or block change of each edge search, ON or OFF,
	// is stored; it also keeps block events that event selection hides.
	wire [7:0] zoneChg = rise[7:0] | fall[7:0];
	wire logRec = |zoneChg;
	wire azt_idx_type logIdx = azt_first({24'h0, zoneChg});
	wire logOff = fall[logIdx[2:0]];
	logic [63:0] recTime [`AZT_NUM_REC];
	logic [63:0] recCur [`AZT_NUM_REC];
	logic [17:0] recInfo [`AZT_NUM_REC];
	logic [3:0] wrPtr_reg;
	logic [3:0] recCount_reg;
	wire [3:0] wrPtr_next = (wrPtr_reg == 4'(`AZT_NUM_REC - 1)) ?
		4'h0 : wrPtr_reg + 4'h1;
	always_ff @(posedge clk) begin
		if (logRec) begin
			recTime[wrPtr_reg] <= timeNow;
			recCur[wrPtr_reg] <= {currentRes, currentC, currentB,
				currentA};
			recInfo[wrPtr_reg] <= {1'b0, logIdx, logOff,
				{chanPressure, chanLight}, settingGroup};
		end
	end
	always_ff @(posedge clk) begin
		if (!rstn) begin
			wrPtr_reg <= 4'h0;
			recCount_reg <= 4'h0;
		end else if (logRec) begin
			wrPtr_reg <= wrPtr_next;
			if (recCount_reg != 4'(`AZT_NUM_REC)) begin
				recCount_reg <= recCount_reg + 4'h1;
			end
		end
	end

	// Condition code of the latest zone trip or block ON edge, sensor code now.
	logic [2:0] cond_reg;
	logic condValid_reg;
	always_ff @(posedge clk) begin
		if (!rstn) begin
			cond_reg <= 3'h0;
			condValid_reg <= 1'b0;
		end else if (|rise[7:0]) begin
			cond_reg <= 3'(azt_first({24'h0, rise[7:0]}));
			condValid_reg <= 1'b1;
		end
	end
	wire [4:0] sensCode = azt_first({14'h0,
		src[25:`AZT_SRC_SENSOR]});
	wire sensAny = |src[25:`AZT_SRC_SENSOR];

	// Newest-first record index, wrapping around the ring.
	wire [4:0] rdBase = {1'b0, wrPtr_reg} + 5'(`AZT_NUM_REC) - 5'h1 -
		{1'b0, recSel_reg};
	wire [4:0] rdIdx = (rdBase >= 5'(`AZT_NUM_REC)) ?
		rdBase - 5'(`AZT_NUM_REC) : rdBase;

	// Interrupt causes; a new cause wins over a clear in one cycle.
	wire [2:0] irqSet = {logRec, newBlock, |(rise[7:0] & 8'h55)};
	wire setupPh = psel & ~penable;
	wire wrEn = psel & penable & pready & pwrite;
	wire [2:0] irqClr = (wrEn && paddr == `AZT_A_IRQ_CLR) ?
		pwdata[2:0] : 3'h0;
	always_ff @(posedge clk) begin
		if (!rstn) begin
			irqStat_reg <= 3'h0;
			irq <= 1'b0;
		end else begin
			irqStat_reg <= (irqStat_reg & ~irqClr) | irqSet;
			irq <= |(((irqStat_reg & ~irqClr) | irqSet) & irqEn_reg);
		end
	end

	// APB: reads latch in setup, writes land only at the ready edge.
	wire [3:0] cfgSel = 4'(paddr[7:2] - 6'h02);
	wire isCfg = paddr >= `AZT_A_ZONE_CFG0 && paddr < `AZT_A_ON_SEL;
	always_ff @(posedge clk) begin
		if (!rstn) begin
			ctrl_reg <= 2'h0;
			zoneEn_reg <= 4'h0;
			onSel_reg <= 26'h0;
			offSel_reg <= 26'h0;
			irqEn_reg <= 3'h0;
			recSel_reg <= 4'h0;
			for (int z = 0; z < 4; z++) begin
				zoneCfg_reg[z] <= 12'h000;
			end
		end else if (wrEn) begin
			if (paddr == `AZT_A_CTRL) ctrl_reg <= pwdata[1:0];
			if (paddr == `AZT_A_ZONE_EN) zoneEn_reg <= pwdata[3:0];
			if (isCfg) zoneCfg_reg[cfgSel[1:0]] <= pwdata[11:0];
			if (paddr == `AZT_A_ON_SEL) onSel_reg <= pwdata[25:0];
			if (paddr == `AZT_A_OFF_SEL) offSel_reg <= pwdata[25:0];
			if (paddr == `AZT_A_IRQ_EN) irqEn_reg <= pwdata[2:0];
			if (paddr == `AZT_A_REC_SEL) recSel_reg <= pwdata[3:0];
		end
	end

	// Read data selection; unmapped addresses answer with an error.
	logic [31:0] rdData;
	logic rdOk;
	always_comb begin
		rdOk = 1'b1;
		rdData = 32'h0;
		unique case (paddr)
		`AZT_A_CTRL: rdData = {30'h0, ctrl_reg};
		`AZT_A_ZONE_EN: rdData = {28'h0, zoneEn_reg};
		`AZT_A_ON_SEL: rdData = {6'h0, onSel_reg};
		`AZT_A_OFF_SEL: rdData = {6'h0, offSel_reg};
		`AZT_A_STATUS: rdData = {16'h0, recCount_reg, 1'b0,
			blockSampled_reg, sensAny, sensCode, condValid_reg,
			cond_reg};
		`AZT_A_IRQ_STAT: rdData = {29'h0, irqStat_reg};
		`AZT_A_IRQ_EN: rdData = {29'h0, irqEn_reg};
		`AZT_A_IRQ_CLR: rdData = 32'h0;
		`AZT_A_REC_SEL: rdData = {28'h0, recSel_reg};
		`AZT_A_REC_TLO: rdData = recTime[rdIdx[3:0]][31:0];
		`AZT_A_REC_THI: rdData = recTime[rdIdx[3:0]][63:32];
		`AZT_A_REC_INFO: rdData = {14'h0, recInfo[rdIdx[3:0]]};
		`AZT_A_REC_AB: rdData = recCur[rdIdx[3:0]][31:0];
		`AZT_A_REC_CR: rdData = recCur[rdIdx[3:0]][63:32];
		default: begin
			if (isCfg) begin
				rdData = {20'h0, zoneCfg_reg[cfgSel[1:0]]};
			end else begin
				rdOk = 1'b0;
			end
		end
		endcase
	end

	// Answer flops: pready rises in the first access cycle.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
		end else begin
			pready <= setupPh;
			pslverr <= setupPh & ~rdOk;
			if (setupPh && !pwrite) begin
				prdata <= rdData;
			end
		end
	end
endmodule // azt_arc_zone_trip

// File: azt_checker.sv
// Port checker of the arc zone trip block.
`timescale 1ns/1ps
module azt_checker import azt_pkg::*; #(
	parameter int CYCLE_CLKS = 16
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [3:0] zoneTrip,
	input wire logic [3:0] zoneBlocked,
	input wire logic displayNotify,
	input wire logic evtValid,
	input wire logic [5:0] evtCode,
	input wire logic irq
);
	// All checks share the one clock and its reset.
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);
	trip_excl_a: assert property ((zoneTrip & zoneBlocked) == 4'h0)
		else $error("zone both tripped and blocked");
	trip_hold_a: assert property ($changed(zoneTrip) |=>
		$stable(zoneTrip)[*8]) else $error("trip moved between ticks");
	notify_block_a: assert property (displayNotify |->
		|(zoneBlocked & ~$past(zoneBlocked, 2)))
		else $error("notice without new block");
	code_range_a: assert property (evtValid |->
		evtCode[5:1] < 5'h1a) else $error("event source out of range");
	apb_answer_a: assert property (psel && !penable |=> pready)
		else $error("no answer in first access cycle");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("ready stood too long");
	err_ready_a: assert property (pslverr |-> pready)
		else $error("error without ready");
	reset_quiet_a: assert property (!$past(rstn) |-> !irq &&
		zoneTrip == 4'h0) else $error("outputs not quiet after reset");
endmodule // azt_checker

// File: azt_partner.sv
// Far side model: blocking matrix and main event buffer.
`timescale 1ns/1ps
module azt_partner (
	input wire logic clk,
	input wire logic blockReq,
	output logic blockIn = 1'b0,
	input wire logic evtValid,
	input wire logic [5:0] evtCode,
	input wire logic [63:0] evtTime,
	input wire logic [63:0] evtCurrents,
	input wire logic displayNotify
);
	logic [5:0] codes[$]; // Stored events, oldest first.
	logic [63:0] times[$]; // Time stamps of the stored events.
	logic [63:0] curs[$]; // Process data of the stored events.
	int nNotify = 0; // Display notices seen.
	// Blocking is a level held well ahead of the next tick.
	always @(posedge clk) begin
		blockIn <= blockReq;
		if (evtValid === 1'b1) begin
			codes.push_back(evtCode);
			times.push_back(evtTime);
			curs.push_back(evtCurrents);
		end
		if (displayNotify === 1'b1) begin
			nNotify++;
		end
	end
endmodule // azt_partner

// File: azt_arc_zone_trip_bench.sv
// Self-checking bench of the arc zone trip block.
`timescale 1ns/1ps
`include "azt_defs.svh"
module azt_arc_zone_trip_bench import azt_pkg::*;;
	localparam int CYC = 16; // Short program cycle keeps runs brief.
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic pready, pslverr, err, blockReq = 1'b0, blockIn, irq;
	logic phaseStart = 1'b0, resStart = 1'b0, ioUnitFault = 1'b0;
	logic [3:0] chanLight = 4'h0, zoneTrip, zoneBlocked;
	logic [63:0] timeNow = 64'h0, evtTime, evtCurrents;
	logic [15:0] currentA = 16'h0, currentB = 16'h0;
	logic [15:0] currentC = 16'h0, currentRes = 16'h0;
	logic optionDigitalInput = 1'b0;
	logic [63:0] tSet = 64'h0; // Stamp at which scenario inputs moved.
	logic [2:0] settingGroup = 3'h0;
	logic displayNotify, evtValid;
	logic [5:0] evtCode;
	int nMismatch = 0, numChecks = 0;
	always #2.5 clk = ~clk;
	// Free-running time stamp source.
	always @(posedge clk) timeNow <= timeNow + 64'h1;
	azt_arc_zone_trip #(.CYCLE_CLKS(CYC)) u_azt_arc_zone_trip (.clk(clk),
		.rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .blockIn(blockIn), .phaseBlocked(1'b0),
		.phaseStart(phaseStart), .resBlocked(1'b0), .resStart(resStart),
		.chanLight(chanLight), .chanPressure(4'h0),
		.optionDigitalInput(optionDigitalInput), .sensorFault(4'h0),
		.ioUnitFault(ioUnitFault), .timeNow(timeNow), .currentA(currentA),
		.currentB(currentB), .currentC(currentC), .currentRes(currentRes),
		.settingGroup(settingGroup), .zoneTrip(zoneTrip),
		.zoneBlocked(zoneBlocked), .displayNotify(displayNotify),
		.evtValid(evtValid), .evtCode(evtCode), .evtTime(evtTime),
		.evtCurrents(evtCurrents), .irq(irq));
	azt_partner u_azt_partner (.clk(clk), .blockReq(blockReq),
		.blockIn(blockIn), .evtValid(evtValid), .evtCode(evtCode),
		.evtTime(evtTime), .evtCurrents(evtCurrents),
		.displayNotify(displayNotify));
	// Prints counts and verdict, then ends the run.
	task automatic printVerdict();
		$display("checks %0d mismatches %0d", numChecks, nMismatch);
		if (nMismatch == 0 && numChecks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// Compares one seen value with its expectation.
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		numChecks++;
		if (seen !== exp) begin
			nMismatch++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// True when a stamp lies within two program cycles after tSet.
	function automatic logic inWin(input logic [63:0] t);
		return t >= tSet && t < tSet + 64'(2 * CYC);
	endfunction
	// One APB transfer; the wait for ready is bounded.
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		for (n = 0; n < 20; n++) begin
			@(posedge clk);
			if (pready === 1'b1) break;
		end
		if (n == 20) begin
			nMismatch++;
			printVerdict();
		end
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Reads a register and compares it.
	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input string nm);
		apb(1'b0, a, 32'h0);
		chk(nm, q, e);
	endtask
	// Two program cycles and four clocks let a tick, its edges and events land.
	task automatic settle();
		repeat (2 * CYC + 4) @(posedge clk);
	endtask
	initial begin
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		rd(`AZT_A_STATUS, 32'h0, "status reset");
		rd(8'h80, 32'h0, "unmapped read");
		chk("slverr", {31'h0, err}, 32'h1);
		apb(1'b1, `AZT_A_IRQ_CLR, 32'h7);
		rd(`AZT_A_IRQ_CLR, 32'h0, "clear reg");
		$display("test reset done");
		apb(1'b1, `AZT_A_ZONE_EN, 32'h1);
		apb(1'b1, `AZT_A_ZONE_CFG0, 32'h5);
		apb(1'b1, `AZT_A_ON_SEL, 32'h03ffffff);
		apb(1'b1, `AZT_A_OFF_SEL, 32'h03ffffff);
		apb(1'b1, `AZT_A_IRQ_EN, 32'h7);
		currentA <= 16'h0123;
		currentB <= 16'h0456;
		currentC <= 16'h0789;
		currentRes <= 16'h0abc;
		settingGroup <= 3'h2;
		phaseStart <= 1'b1;
		resStart <= 1'b1;
		chanLight <= 4'h1;
		tSet = timeNow;
		settle();
		chk("trip", {28'h0, zoneTrip}, 32'h1);
		chk("blocked", {28'h0, zoneBlocked}, 32'h0);
		chk("event count", u_azt_partner.codes.size(), 32'h4);
		chk("first event", {26'h0, u_azt_partner.codes[0]}, 32'h0);
		chk("evt cur lo", u_azt_partner.curs[0][31:0], 32'h04560123);
		chk("evt cur hi", u_azt_partner.curs[0][63:32], 32'h0abc0789);
		chk("evt time", {31'h0, inWin(u_azt_partner.times[0])}, 32'h1);
		rd(`AZT_A_STATUS, 32'h1218, "status trip");
		chk("irq raised", {31'h0, irq}, 32'h1);
		apb(1'b1, `AZT_A_REC_SEL, 32'h0);
		rd(`AZT_A_REC_AB, 32'h04560123, "record currents");
		rd(`AZT_A_REC_INFO, 32'h0000000a, "record info");
		rd(`AZT_A_REC_CR, 32'h0abc0789, "record res and c");
		apb(1'b0, `AZT_A_REC_TLO, 32'h0);
		chk("record time", {31'h0, inWin({32'h0, q})}, 32'h1);
		apb(1'b1, `AZT_A_IRQ_CLR, 32'h7);
		// The clear lands at the ready edge; irq follows that edge.
		@(posedge clk);
		chk("irq cleared", {31'h0, irq}, 32'h0);
		$display("test trip done");
		phaseStart <= 1'b0;
		resStart <= 1'b0;
		chanLight <= 4'h0;
		blockReq <= 1'b1;
		ioUnitFault <= 1'b1;
		apb(1'b1, `AZT_A_IRQ_EN, 32'h0);
		settle();
		u_azt_partner.codes.delete();
		phaseStart <= 1'b1;
		chanLight <= 4'h1;
		settle();
		chk("block", {28'h0, zoneBlocked}, 32'h1);
		chk("no trip", {28'h0, zoneTrip}, 32'h0);
		chk("notice", u_azt_partner.nNotify, 32'h1);
		chk("block event", {26'h0, u_azt_partner.codes[0]}, 32'h2);
		rd(`AZT_A_STATUS, 32'h3619, "status block");
		chk("irq masked", {31'h0, irq}, 32'h0);
		rd(`AZT_A_IRQ_STAT, 32'h6, "irq status");
		$display("test block done");
		phaseStart <= 1'b0;
		chanLight <= 4'h0;
		blockReq <= 1'b0;
		ioUnitFault <= 1'b0;
		apb(1'b1, `AZT_A_ON_SEL, 32'h0);
		apb(1'b1, `AZT_A_OFF_SEL, 32'h0);
		apb(1'b1, `AZT_A_CTRL, 32'h3);
		settle();
		u_azt_partner.codes.delete();
		phaseStart <= 1'b1;
		chanLight <= 4'h1;
		settle();
		chk("forced block", {28'h0, zoneBlocked}, 32'h1);
		chk("events off", u_azt_partner.codes.size(), 32'h0);
		$display("test forcing done");
		// Zone two needs input and a channel, zone three input alone.
		apb(1'b1, `AZT_A_CTRL, 32'h0);
		apb(1'b1, `AZT_A_ZONE_EN, 32'h7);
		apb(1'b1, `AZT_A_ZONE_CFG0 + 8'h04, 32'h800);
		apb(1'b1, `AZT_A_ZONE_CFG0 + 8'h08, 32'h400);
		optionDigitalInput <= 1'b1;
		settle();
		chk("input modes", {28'h0, zoneTrip}, 32'h7);
		phaseStart <= 1'b0;
		chanLight <= 4'h0;
		settle();
		chk("light-in only", {28'h0, zoneTrip}, 32'h4);
		$display("test input modes done");
		printVerdict();
	end
endmodule // azt_arc_zone_trip_bench
bind azt_arc_zone_trip azt_checker #(.CYCLE_CLKS(CYCLE_CLKS)) u_azt_checker (
	.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
	.pready(pready), .pslverr(pslverr), .zoneTrip(zoneTrip),
	.zoneBlocked(zoneBlocked), .displayNotify(displayNotify),
	.evtValid(evtValid), .evtCode(evtCode), .irq(irq));
